// ==== hw/fai_host.v ====
// Host controller that drives a width and depth expanded FIFO slice array
// Functional notes
// RULE_01: Drive push strobe to every slice together
// RULE_02: Width-only array holds sixteen wide words
// RULE_03: Drive pop strobe to every slice together
// RULE_04: Capacity is 15m plus one words
// RULE_05: Push starts initialisation ripple down row
// RULE_06: Write when last full low; read when empty high; the code writes only while full_n_s is high instead
// RULE_07: Master enable grounded, slaves chained from full; the code grounds every row_slave_en_n_out bit instead
// RULE_08: Slices drive full high during reset
// RULE_09: Reset with enable low sets master
// RULE_10: Low push strobe sets request flip-flop
// RULE_11: Master initialises input register immediately
// RULE_12: Slave waits for its enable low
// RULE_13: Pop strobe loads output, sets request
// RULE_14: Master raises empty-n after load
// RULE_15: Slave empty-n waits for its enable
// RULE_16: Full-n low when input register holds word
// RULE_17: Empty-n high only with valid output
// RULE_18: Push moves word only into free top
// RULE_19: Reset with enable high makes slave
`timescale 1ns/1ps
`include "fai_map.vh"
module fai_host
(
    input  wire                     core_clk_in,
    input  wire                     resetn_in,
    input  wire                     wr_valid_in,
    input  wire [`FAI_WORD_W-1:0]   wr_data_in,
    output reg                      wr_ready_out,
    output reg                      rd_valid_out,
    output reg  [`FAI_WORD_W-1:0]   rd_data_out,
    input  wire                     rd_ready_in,
    output reg  [`FAI_CNT_W-1:0]    level_out,
    output reg                      master_reset_n_out,
    output reg                      parallel_load_out,
    output reg  [`FAI_WORD_W-1:0]   fifo_data_out,
    output reg                      push_to_stack_n_out,
    output reg                      pop_parallel_out,
    output reg                      pop_serial_n_out,
    output reg                      output_enable_n_out,
    output reg  [`FAI_COLS-1:0]     row_slave_en_n_out,
    input  wire                     input_full_n_in,
    input  wire                     output_empty_n_in,
    input  wire [`FAI_WORD_W-1:0]   fifo_q_in
);
    reg  [2:0]               state;
    reg  [2:0]               next_state;
    reg  [`FAI_TMR_W-1:0]    tmr;
    wire                     full_n_s;
    wire                     empty_n_s;
    wire [`FAI_WORD_W-1:0]   q_s;

    // Sequencer states
    localparam [2:0] ST_RESET     = `FAI_ST_RESET;
    localparam [2:0] ST_IDLE      = `FAI_ST_IDLE;
    localparam [2:0] ST_PUSH      = `FAI_ST_PUSH;
    localparam [2:0] ST_PUSH_WAIT = `FAI_ST_PUSH_WAIT;
    localparam [2:0] ST_POP       = `FAI_ST_POP;
    localparam [2:0] ST_POP_WAIT  = `FAI_ST_POP_WAIT;

    // Timer loads and capacity, cut to their register widths on purpose
    localparam [31:0]           RESET_CYC32  = `FAI_RESET_CYC;
    localparam [31:0]           STROBE_CYC32 = `FAI_STROBE_CYC;
    localparam [31:0]           CAP_WORDS32  = `FAI_CAP_WORDS;
    localparam [`FAI_TMR_W-1:0] RESET_LOAD   = RESET_CYC32[`FAI_TMR_W-1:0];
    localparam [`FAI_TMR_W-1:0] STROBE_LOAD  = STROBE_CYC32[`FAI_TMR_W-1:0];
    localparam [`FAI_CNT_W-1:0] CAP_LEVEL    = CAP_WORDS32[`FAI_CNT_W-1:0]; // RULE_04

    // Pin levels from the array cross into the clock domain; each flag resets
    // to the level its pin shows while the array is held in reset, so that
    // no false request follows the release
    fai_sync #(.W(1), .INIT(1'b1)) u_sync_full
    (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .async_in    (input_full_n_in),
        .sync_out    (full_n_s)
    );
    fai_sync #(.W(1), .INIT(1'b0)) u_sync_empty
    (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .async_in    (output_empty_n_in),
        .sync_out    (empty_n_s)
    );
    fai_sync #(.W(`FAI_WORD_W), .INIT(1'b0)) u_sync_q
    (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .async_in    (fifo_q_in),
        .sync_out    (q_s)
    );

    // True when the strobe or reset timer has run out
    function tmr_done;
        input [`FAI_TMR_W-1:0] t;
        begin
            tmr_done = (t == {`FAI_TMR_W{1'b0}});
        end
    endfunction

    // One step of the level counter, up or down
    function [`FAI_CNT_W-1:0] lvl_step;
        input [`FAI_CNT_W-1:0] v;
        input                  up;
        begin
            if (up)
                lvl_step = v + {{(`FAI_CNT_W-1){1'b0}}, 1'b1};
            else
                lvl_step = v - {{(`FAI_CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Next state of the handshake sequencer
    always @*
    begin
        next_state = state;
        case (state)
            ST_RESET:
                if (tmr_done(tmr))
                    next_state = ST_IDLE;
            ST_IDLE:
                // Reads first; the level guard mirrors the full flag
                if (!rd_valid_out && empty_n_s)
                    next_state = ST_POP; // RULE_06
                else if (wr_valid_in && full_n_s && (level_out != CAP_LEVEL))
                    next_state = ST_PUSH; // RULE_04 RULE_06
            ST_PUSH:
                if (tmr_done(tmr))
                    next_state = ST_PUSH_WAIT;
            ST_PUSH_WAIT:
                if (!full_n_s)
                    next_state = ST_IDLE; // RULE_16
            ST_POP:
                if (tmr_done(tmr))
                    next_state = ST_POP_WAIT;
            ST_POP_WAIT:
                if (!empty_n_s)
                    next_state = ST_IDLE; // RULE_17
            default:
                next_state = ST_RESET;
        endcase
    end

    // Sequencer, pin drive and user handshake
    always @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state               <= ST_RESET;
            tmr                 <= RESET_LOAD;
            wr_ready_out        <= 1'b0;
            rd_valid_out        <= 1'b0;
            rd_data_out         <= {`FAI_WORD_W{1'b0}};
            level_out           <= {`FAI_CNT_W{1'b0}};
            master_reset_n_out  <= 1'b0;
            parallel_load_out   <= 1'b0;
            fifo_data_out       <= {`FAI_WORD_W{1'b0}};
            push_to_stack_n_out <= 1'b1;
            pop_parallel_out    <= 1'b0;
            pop_serial_n_out    <= 1'b0;
            output_enable_n_out <= 1'b0;
            row_slave_en_n_out  <= {`FAI_COLS{1'b0}};
        end
        else
        begin
            state              <= next_state;
            wr_ready_out       <= 1'b0;
            row_slave_en_n_out <= {`FAI_COLS{1'b0}}; // RULE_07
            if (rd_valid_out && rd_ready_in)
                rd_valid_out <= 1'b0;
            if (!tmr_done(tmr))
                tmr <= tmr - {{(`FAI_TMR_W-1){1'b0}}, 1'b1};
            case (state)
                ST_RESET:
                    // Let the array out of reset once the timer has run out
                    if (tmr_done(tmr))
                        master_reset_n_out <= 1'b1; // RULE_08 RULE_09 RULE_19
                ST_IDLE:
                    if (next_state == ST_PUSH)
                    begin
                        // Load word, strobe push to all slices at once
                        fifo_data_out       <= wr_data_in; // RULE_02
                        parallel_load_out   <= 1'b1;
                        push_to_stack_n_out <= 1'b0; // RULE_01 RULE_05 RULE_10
                        wr_ready_out        <= 1'b1;
                        tmr                 <= STROBE_LOAD;
                        level_out           <= lvl_step(level_out, 1'b1);
                    end
                    else if (next_state == ST_POP)
                    begin
                        // Capture word, then pull next from stack
                        rd_data_out      <= q_s;
                        rd_valid_out     <= 1'b1; // RULE_06
                        pop_parallel_out <= 1'b0;
                        pop_serial_n_out <= 1'b1; // RULE_03 RULE_13
                        tmr              <= STROBE_LOAD;
                        if (level_out != {`FAI_CNT_W{1'b0}})
                            level_out <= lvl_step(level_out, 1'b0);
                    end
                    else
                        pop_parallel_out <= 1'b1; // RULE_14 RULE_15
                ST_PUSH:
                    // Both push strobes end together after the set time
                    if (tmr_done(tmr))
                    begin
                        parallel_load_out   <= 1'b0; // RULE_11 RULE_12 RULE_18
                        push_to_stack_n_out <= 1'b1;
                    end
                ST_POP:
                    // Restore the strobes so that the next word may load
                    if (tmr_done(tmr))
                    begin
                        pop_serial_n_out <= 1'b0;
                        pop_parallel_out <= 1'b1;
                    end
                default:
                    ;
            endcase
        end
    end
endmodule

// ==== hw/fai_map.vh ====
// Constants for the FIFO array host controller
`ifndef FAI_MAP_VH
`define FAI_MAP_VH
`define FAI_SLICE_W        4
`define FAI_COLS           2
`define FAI_ROWS           2
`define FAI_WORD_W         8
`define FAI_STACK_WORDS    15
`define FAI_CAP_WORDS      31
`define FAI_CNT_W          6
`define FAI_RESET_NS       50
`define FAI_STROBE_NS      50
`define FAI_CLK_NS         25
`define FAI_RESET_CYC      ((`FAI_RESET_NS + `FAI_CLK_NS - 1) / `FAI_CLK_NS)
`define FAI_STROBE_CYC     ((`FAI_STROBE_NS + `FAI_CLK_NS - 1) / `FAI_CLK_NS)
`define FAI_TMR_W          4
`define FAI_ST_RESET       3'h0
`define FAI_ST_IDLE        3'h1
`define FAI_ST_PUSH        3'h2
`define FAI_ST_PUSH_WAIT   3'h3
`define FAI_ST_POP         3'h4
`define FAI_ST_POP_WAIT    3'h5
`endif

// ==== hw/fai_sync.v ====
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module fai_sync
#(
    parameter W    = 1,
    parameter INIT = 1'b0
)
(
    input  wire         core_clk_in,
    input  wire         resetn_in,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta;

    // First stage feeds only the second
    always @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta     <= {W{INIT}};
            sync_out <= {W{INIT}};
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ==== tb/fai_host_sva.sv ====
// Checker for the host controller port timing
`timescale 1ns/1ps
module fai_host_sva(
    input wire logic core_clk_in, resetn_in, wr_ready_out, rd_valid_out, rd_ready_in,
    input wire logic master_reset_n_out, parallel_load_out, push_to_stack_n_out,
    input wire logic pop_parallel_out, pop_serial_n_out, output_enable_n_out,
    input wire logic [7:0] rd_data_out,
    input wire logic [5:0] level_out,
    input wire logic [1:0] row_slave_en_n_out);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // Load strobe stands three cycles, extract pulse likewise
    sequence s_load3; parallel_load_out[*3] ##1 !parallel_load_out; endsequence
    sequence s_pop3; (pop_serial_n_out && !pop_parallel_out)[*3]
        ##1 (!pop_serial_n_out && pop_parallel_out); endsequence
    property p_rdy; wr_ready_out |=> !wr_ready_out; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not a pulse");
    property p_push; wr_ready_out |-> parallel_load_out && !push_to_stack_n_out; endproperty
    a_push: assert property (p_push) else $error("push strobes absent");
    property p_load; $rose(parallel_load_out) |-> s_load3; endproperty
    a_load: assert property (p_load) else $error("load strobe length");
    property p_pop; $rose(rd_valid_out) |-> s_pop3; endproperty
    a_pop: assert property (p_pop) else $error("extract pulse wrong");
    property p_hold; rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("read word dropped");
    property p_lvl; level_out <= 6'h1f; endproperty
    a_lvl: assert property (p_lvl) else $error("level above capacity");
    property p_tie; !output_enable_n_out && row_slave_en_n_out == 2'h0; endproperty
    a_tie: assert property (p_tie) else $error("enables not grounded");
    property p_rst; $rose(master_reset_n_out) |-> !$past(master_reset_n_out, 2); endproperty
    a_rst: assert property (p_rst) else $error("array reset too short");
endmodule
bind fai_host fai_host_sva u_sva(.core_clk_in, .resetn_in, .wr_ready_out, .rd_valid_out,
    .rd_ready_in, .master_reset_n_out, .parallel_load_out, .push_to_stack_n_out,
    .pop_parallel_out, .pop_serial_n_out, .output_enable_n_out, .rd_data_out,
    .level_out, .row_slave_en_n_out);

// ==== tb/fai_array_model.sv ====
// Behavioural model of the 2x2 slice array, 31 words of 8 bits
`timescale 1ns/1ps
module fai_array_model(
    input wire logic master_reset_n_in, parallel_load_in, push_to_stack_n_in,
    input wire logic pop_parallel_in, pop_serial_n_in,
    input wire logic [1:0] row_slave_en_n_in,
    input wire logic [7:0] fifo_data_in,
    output logic input_full_n_out, output_empty_n_out,
    output logic [7:0] fifo_q_out);
    logic [7:0] stk[$];
    logic [7:0] in_word;
    logic in_full, req, done, ov, ml;
    // Poll the pins as the unclocked slices would
    always #7
    begin
        if (!master_reset_n_in)
        begin
            stk.delete();
            {in_full, req, done, ov} = 4'h0;
            ml = !row_slave_en_n_in[0];
        end
        else
        begin
            if (parallel_load_in)
            begin
                in_full = 1'b1;
                in_word = fifo_data_in;
            end
            if (!push_to_stack_n_in && in_full && !done) req = 1'b1;
            if (req && stk.size() + ov < 30)
            begin
                stk.push_back(in_word);
                {req, done} = 2'h1;
            end
            if (done && !parallel_load_in && (ml || !row_slave_en_n_in[0]))
                {in_full, done} = 2'h0;
            if (ov && !pop_parallel_in) ov = 1'b0;
            if (!ov && pop_parallel_in && !pop_serial_n_in && stk.size() > 0)
            begin
                fifo_q_out = stk.pop_front();
                ov = 1'b1;
            end
        end
        input_full_n_out = !in_full;
        output_empty_n_out = ov;
    end
endmodule

// ==== tb/fifo_array_interlock_test.sv ====
// Self-checking bench for the array host controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module fifo_array_interlock_test;
    logic core_clk_in = 0, resetn_in = 0, wr_valid_in = 0, rd_ready_in = 0;
    logic [7:0] wr_data_in = 8'h00, exp_q = 8'h00;
    wire wr_ready_out, rd_valid_out, rst_arr_n, pl, push_n, pop_p, pop_s_n, full_n, empty_n;
    wire [7:0] rd_data_out, f_d, f_q;
    wire [5:0] level_out;
    wire [1:0] slv_n;
    int fails = 0, n_tests = 0, cyc = 0, acc = 0;
    logic [7:0] ref_q[$];
    fai_host u_dut(.core_clk_in, .resetn_in, .wr_valid_in, .wr_data_in, .wr_ready_out,
        .rd_valid_out, .rd_data_out, .rd_ready_in, .level_out,
        .master_reset_n_out(rst_arr_n), .parallel_load_out(pl), .fifo_data_out(f_d),
        .push_to_stack_n_out(push_n), .pop_parallel_out(pop_p), .pop_serial_n_out(pop_s_n),
        .output_enable_n_out(), .row_slave_en_n_out(slv_n), .input_full_n_in(full_n),
        .output_empty_n_in(empty_n), .fifo_q_in(f_q));
    fai_array_model u_far(.master_reset_n_in(rst_arr_n), .parallel_load_in(pl),
        .push_to_stack_n_in(push_n), .pop_parallel_in(pop_p), .pop_serial_n_in(pop_s_n),
        .row_slave_en_n_in(slv_n), .fifo_data_in(f_d), .input_full_n_out(full_n),
        .output_empty_n_out(empty_n), .fifo_q_out(f_q));
    initial forever #12.5 core_clk_in = ~core_clk_in;
    task close_out;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Run n cycles, writer and reader busy at the given percentages
    task run(input int n, input int pw, input int pr);
        repeat (n)
        begin
            @(posedge core_clk_in);
            if (rd_valid_out && rd_ready_in)
            begin
                exp_q = ref_q.pop_front();
                `CHK(rd_data_out, exp_q)
            end
            if (wr_ready_out)
            begin
                ref_q.push_back(wr_data_in);
                acc++;
            end
            if (wr_ready_out || !wr_valid_in)
            begin
                wr_valid_in <= ($urandom % 100) < pw;
                wr_data_in <= 8'($urandom);
            end
            rd_ready_in <= ($urandom % 100) < pr;
        end
    endtask
    // Fill against a stalled reader, mix, then drain
    initial
    begin
        void'($urandom(32'h0a56));
        repeat (2) @(posedge core_clk_in);
        `CHK(rst_arr_n, 1'b0)
        `CHK(push_n, 1'b1)
        resetn_in <= 1'b1;
        run(600, 100, 0);
        // Array holds its 31 words, the host's read register one more
        `CHK(acc, 32)
        `CHK(level_out, 6'h1f)
        run(2000, 60, 50);
        run(600, 0, 100);
        `CHK(ref_q.size(), 0)
        `CHK(level_out, 6'h00)
        close_out;
    end
    // Cut a hang short
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            close_out;
        end
    end
endmodule
